// ---- rtl/eev_apb_slave.sv ----
`timescale 1ns/1ps
module eev_apb_slave (
   clk,
   rst,
   psel,
   penable,
   pwrite,
   paddr,
   pwdata,
   pready,
   pslverr,
   acc
);
   input wire logic clk;
   input wire logic rst;
   input wire logic psel;
   input wire logic penable;
   input wire logic pwrite;
   input wire logic [31:0] paddr;
   input wire logic [31:0] pwdata;
   output logic pready;
   output logic pslverr;
   output eev_pkg::eev_acc_t acc;

   // ==========================================
   // Zero-wait slave; access acts at the access phase edge
   always_comb begin
      pready = 1'b1;
      pslverr = 1'b0;
      acc.wr = psel & penable & pwrite;
      acc.rd = psel & penable & ~pwrite;
      acc.addr = paddr;
      acc.wdata = pwdata;
   end

   // Unused clock and reset kept for a uniform port list
   logic unusedTie;
   always_comb begin
      unusedTie = clk ^ rst;
   end
endmodule

// ---- rtl/eev_pkg.sv ----
// Behaviour
// - Software interrupt instruction captures its 8-bit immediate into trap bits 9..2.
// - Software writes change only trap immediate bits 9..2.
// - Reserved bits of every exception register read as zero.
// - Reset or general exception loads its 12-bit code into general event code.
// - Software may rewrite general event code bits 11..0; upper bits read-only.
// - General event code is 0x000 after power-on reset, 0x020 after manual reset.
// - Interrupt acceptance loads a 12-bit source code into the interrupt event register.
// - Software may rewrite interrupt event bits 11..0; upper bits read-only.
// - Mirror interrupt event register at 0xA4000000 is read-only; writes ignored.
// - Memory-access exception stores the 32-bit logical address into fault address.
// - Fault address register is fully readable and writable over 32 bits.
// - Acceptance writes the code into general or interrupt registers by exception type.
// - Trap and address capture is one ordered step after save, before vector jump.
package eev_pkg;

   // ==========================================
   // Register byte addresses
   localparam logic [31:0] ADDR_IRQ_MIRROR = 32'hA4000000;
   localparam logic [31:0] ADDR_TRAP_IMM = 32'h0FFFFFD0;
   localparam logic [31:0] ADDR_GEN_EVENT = 32'h0FFFFFD4;
   localparam logic [31:0] ADDR_IRQ_EVENT = 32'h0FFFFFD8;
   localparam logic [31:0] ADDR_FAULT_ADDR = 32'h0FFFFFFC;
   localparam logic [31:0] ADDR_IRQ_STATUS = 32'h0FFFFFE0;
   localparam logic [31:0] ADDR_IRQ_MASK = 32'h0FFFFFE4;

   // ==========================================
   // Field layout and reset values
   localparam int TRAP_LSB = 2;
   localparam int TRAP_MSB = 9;
   localparam int CODE_MSB = 11;
   localparam logic [11:0] GEN_CODE_POR = 12'h000;
   localparam logic [11:0] GEN_CODE_MANUAL = 12'h020;
   localparam logic [7:0] TRAP_RESET = 8'h00;
   localparam logic [11:0] CODE_RESET = 12'h000;
   localparam logic [31:0] ADDR_RESET = 32'h00000000;
   localparam int NUM_EVT = 4;
   localparam int EVT_TRAP = 0;
   localparam int EVT_GEN = 1;
   localparam int EVT_IRQ = 2;
   localparam int EVT_FAULT = 3;

   // Acceptance step
   typedef enum {
      EEV_IDLE,
      EEV_CODE,
      EEV_CAPTURE
   } eev_state_t;

   // Exception request carried from the sequencer
   typedef struct packed {
      logic valid;
      logic isIrq;
      logic isTrap;
      logic isMemFault;
      logic [11:0] code;
      logic [7:0] trapImm;
      logic [31:0] faultAddr;
   } eev_exc_t;

   // Decoded APB access
   typedef struct packed {
      logic wr;
      logic rd;
      logic [31:0] addr;
      logic [31:0] wdata;
   } eev_acc_t;

endpackage

// ---- rtl/eev_reset_cause.sv ----
`timescale 1ns/1ps
module eev_reset_cause (
   clk,
   rst,
   manualResetReq,
   resetCode
);
   input wire logic clk;
   input wire logic rst;
   input wire logic manualResetReq;
   output logic [11:0] resetCode;

   // ==========================================
   // Manual reset pin crosses into clk domain
   logic manSync1;
   logic manSync2;
   logic [11:0] next_resetCode;

   always_comb begin
      next_resetCode = resetCode;
      if (manSync2) begin
         next_resetCode = eev_pkg::GEN_CODE_MANUAL;
      end
   end

   // Cause latched while rst high; power-on code by default
   always_ff @(posedge clk) begin
      manSync1 <= manualResetReq;
      manSync2 <= manSync1;
      if (rst & ~manSync2) begin
         resetCode <= eev_pkg::GEN_CODE_POR;
      end else begin
         resetCode <= next_resetCode;
      end
   end
endmodule

// ---- rtl/eev_top.sv ----
`timescale 1ns/1ps
module eev_top (
   clk,
   rst,
   manualResetReq,
   psel,
   penable,
   pwrite,
   paddr,
   pwdata,
   prdata,
   pready,
   pslverr,
   excIn,
   excDone,
   irqOut
);
   input wire logic clk;
   input wire logic rst;
   input wire logic manualResetReq;
   input wire logic psel;
   input wire logic penable;
   input wire logic pwrite;
   input wire logic [31:0] paddr;
   input wire logic [31:0] pwdata;
   output logic [31:0] prdata;
   output logic pready;
   output logic pslverr;
   input wire eev_pkg::eev_exc_t excIn;
   output logic excDone;
   output logic irqOut;

   // ==========================================
   // Bus slave and reset cause
   eev_pkg::eev_acc_t acc;
   logic [11:0] resetCode;

   eev_apb_slave uBus (
      .clk(clk),
      .rst(rst),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pready(pready),
      .pslverr(pslverr),
      .acc(acc)
   );

   eev_reset_cause uCause (
      .clk(clk),
      .rst(rst),
      .manualResetReq(manualResetReq),
      .resetCode(resetCode)
   );

   // Address match shared by write and read decode
   function automatic logic hit(input logic [31:0] a, input logic [31:0] ref_a);
      hit = (a == ref_a);
   endfunction

   // ==========================================
   // Acceptance sequencer
   eev_pkg::eev_state_t state;
   eev_pkg::eev_state_t next_state;
   eev_pkg::eev_exc_t held;
   eev_pkg::eev_exc_t next_held;
   logic next_excDone;

   // Request held, code written, then trap and address; done marks vector jump
   always_comb begin
      next_state = state;
      next_held = held;
      next_excDone = 1'b0;
      case (state)
         eev_pkg::EEV_IDLE: begin
            if (excIn.valid) begin
               next_held = excIn;
               next_state = eev_pkg::EEV_CODE;
            end
         end
         eev_pkg::EEV_CODE: begin
            next_state = eev_pkg::EEV_CAPTURE;
         end
         eev_pkg::EEV_CAPTURE: begin
            next_excDone = 1'b1;
            next_state = eev_pkg::EEV_IDLE;
         end
         default: begin
            next_state = eev_pkg::EEV_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= eev_pkg::EEV_IDLE;
         held <= '0;
         excDone <= 1'b0;
      end else begin
         state <= next_state;
         held <= next_held;
         excDone <= next_excDone;
      end
   end

   // ==========================================
   // Exception registers
   logic [7:0] trapImm;
   logic [11:0] genCode;
   logic [11:0] irqCode;
   logic [11:0] irqMirror;
   logic [31:0] faultAddr;
   logic [7:0] next_trapImm;
   logic [11:0] next_genCode;
   logic [11:0] next_irqCode;
   logic [11:0] next_irqMirror;
   logic [31:0] next_faultAddr;
   logic stepCode;
   logic stepCap;
   logic [eev_pkg::NUM_EVT-1:0] evt;

   // Software first, hardware capture after so it takes priority
   always_comb begin
      stepCode = (state == eev_pkg::EEV_CODE);
      stepCap = (state == eev_pkg::EEV_CAPTURE);
      next_trapImm = trapImm;
      next_genCode = genCode;
      next_irqCode = irqCode;
      next_irqMirror = irqMirror;
      next_faultAddr = faultAddr;
      evt = '0;
      if (acc.wr) begin
         if (hit(acc.addr, eev_pkg::ADDR_TRAP_IMM)) begin
            next_trapImm = acc.wdata[eev_pkg::TRAP_MSB:eev_pkg::TRAP_LSB];
         end else if (hit(acc.addr, eev_pkg::ADDR_GEN_EVENT)) begin
            next_genCode = acc.wdata[eev_pkg::CODE_MSB:0];
         end else if (hit(acc.addr, eev_pkg::ADDR_IRQ_EVENT)) begin
            next_irqCode = acc.wdata[eev_pkg::CODE_MSB:0];
         end else if (hit(acc.addr, eev_pkg::ADDR_FAULT_ADDR)) begin
            next_faultAddr = acc.wdata;
         end
         // Mirror address falls through: write ignored
      end
      if (stepCode) begin
         if (held.isIrq) begin
            next_irqCode = held.code;
            next_irqMirror = held.code;
            evt[eev_pkg::EVT_IRQ] = 1'b1;
         end else begin
            next_genCode = held.code;
            evt[eev_pkg::EVT_GEN] = 1'b1;
         end
      end
      if (stepCap) begin
         if (held.isTrap) begin
            next_trapImm = held.trapImm;
            evt[eev_pkg::EVT_TRAP] = 1'b1;
         end
         if (held.isMemFault) begin
            next_faultAddr = held.faultAddr;
            evt[eev_pkg::EVT_FAULT] = 1'b1;
         end
      end
   end

   // Reset loads the cause code; others are cleared to a defined value
   always_ff @(posedge clk) begin
      if (rst) begin
         trapImm <= eev_pkg::TRAP_RESET;
         genCode <= resetCode;
         irqCode <= eev_pkg::CODE_RESET;
         irqMirror <= eev_pkg::CODE_RESET;
         faultAddr <= eev_pkg::ADDR_RESET;
      end else begin
         trapImm <= next_trapImm;
         genCode <= next_genCode;
         irqCode <= next_irqCode;
         irqMirror <= next_irqMirror;
         faultAddr <= next_faultAddr;
      end
   end

   // ==========================================
   // Interrupt status and mask
   logic [eev_pkg::NUM_EVT-1:0] irqStatus;
   logic [eev_pkg::NUM_EVT-1:0] irqMask;
   logic [eev_pkg::NUM_EVT-1:0] next_irqStatus;
   logic [eev_pkg::NUM_EVT-1:0] next_irqMask;
   logic statusRead;

   // Read clears only the bits the reader was shown, since prdata was taken a cycle early;
   // an event landing at the setup edge or in the access cycle survives
   always_comb begin
      statusRead = acc.rd & hit(acc.addr, eev_pkg::ADDR_IRQ_STATUS);
      next_irqStatus = irqStatus;
      if (statusRead) begin
         next_irqStatus = irqStatus & ~prdata[eev_pkg::NUM_EVT-1:0];
      end
      next_irqStatus = next_irqStatus | evt;
      next_irqMask = irqMask;
      if (acc.wr & hit(acc.addr, eev_pkg::ADDR_IRQ_MASK)) begin
         next_irqMask = acc.wdata[eev_pkg::NUM_EVT-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irqStatus <= '0;
         irqMask <= '0;
      end else begin
         irqStatus <= next_irqStatus;
         irqMask <= next_irqMask;
      end
   end

   assign irqOut = |(irqStatus & irqMask);

   // ==========================================
   // Read data; reserved bits and unmapped addresses give zero
   logic [31:0] next_prdata;

   always_comb begin
      next_prdata = 32'h00000000;
      if (hit(paddr, eev_pkg::ADDR_TRAP_IMM)) begin
         next_prdata[eev_pkg::TRAP_MSB:eev_pkg::TRAP_LSB] = trapImm;
      end else if (hit(paddr, eev_pkg::ADDR_GEN_EVENT)) begin
         next_prdata[eev_pkg::CODE_MSB:0] = genCode;
      end else if (hit(paddr, eev_pkg::ADDR_IRQ_EVENT)) begin
         next_prdata[eev_pkg::CODE_MSB:0] = irqCode;
      end else if (hit(paddr, eev_pkg::ADDR_IRQ_MIRROR)) begin
         next_prdata[eev_pkg::CODE_MSB:0] = irqMirror;
      end else if (hit(paddr, eev_pkg::ADDR_FAULT_ADDR)) begin
         next_prdata = faultAddr;
      end else if (hit(paddr, eev_pkg::ADDR_IRQ_STATUS)) begin
         next_prdata[eev_pkg::NUM_EVT-1:0] = irqStatus;
      end else if (hit(paddr, eev_pkg::ADDR_IRQ_MASK)) begin
         next_prdata[eev_pkg::NUM_EVT-1:0] = irqMask;
      end
   end

   // Registered in setup phase, valid during access phase
   always_ff @(posedge clk) begin
      if (rst) begin
         prdata <= 32'h00000000;
      end else begin
         prdata <= next_prdata;
      end
   end

   // ==========================================
   // Checks
   AST_TRAP_CAPTURE: assert property (@(posedge clk) disable iff (rst)
      (stepCap && held.isTrap) |=> (trapImm == $past(held.trapImm)))
      else $error("trap immediate not captured");

   AST_HW_WINS: assert property (@(posedge clk) disable iff (rst)
      (stepCode && !held.isIrq) |=> (genCode == $past(held.code)))
      else $error("general code lost to software write");

   AST_IRQ_CODE: assert property (@(posedge clk) disable iff (rst)
      (stepCode && held.isIrq)
      |=> (irqCode == $past(held.code) && irqMirror == $past(held.code)))
      else $error("interrupt codes differ after capture");

   AST_MIRROR_RO: assert property (@(posedge clk) disable iff (rst)
      (!stepCode) |=> $stable(irqMirror))
      else $error("mirror changed without capture");

   AST_FAULT_CAP: assert property (@(posedge clk) disable iff (rst)
      (stepCap && held.isMemFault) |=> (faultAddr == $past(held.faultAddr)))
      else $error("fault address not captured");

   AST_FAULT_RW: assert property (@(posedge clk) disable iff (rst)
      (acc.wr && hit(acc.addr, eev_pkg::ADDR_FAULT_ADDR) && !stepCap)
      |=> (faultAddr == $past(acc.wdata)))
      else $error("fault address write lost");

   AST_TRAP_RSVD: assert property (@(posedge clk) disable iff (rst)
      (psel && !penable && hit(paddr, eev_pkg::ADDR_TRAP_IMM))
      |=> (prdata[31:10] == 22'h000000 && prdata[1:0] == 2'h0))
      else $error("trap reserved bits not zero");

   AST_ORDER: assert property (@(posedge clk) disable iff (rst)
      (state == eev_pkg::EEV_IDLE && excIn.valid) |=> ##1 stepCap ##1 excDone)
      else $error("acceptance order broken");

   AST_GEN_WR: assert property (@(posedge clk) disable iff (rst)
      (acc.wr && hit(acc.addr, eev_pkg::ADDR_GEN_EVENT) && !stepCode)
      |=> (genCode == $past(acc.wdata[11:0])))
      else $error("general code write lost");

   AST_RESET_CODE: assert property (@(posedge clk)
      $fell(rst) |-> (genCode == eev_pkg::GEN_CODE_POR
         || genCode == eev_pkg::GEN_CODE_MANUAL))
      else $error("bad reset code");
endmodule

// ---- tb/eev_seq_model.sv ----
`timescale 1ns/1ps
module eev_seq_model (
   clk,
   excIn,
   excDone
);
   input wire logic clk;
   output eev_pkg::eev_exc_t excIn;
   input wire logic excDone;
   int lastLat = 0;
   logic timedOut = 1'h0;

   // =====================
   // Sequencer side
   // Quiet until the first request
   initial begin
      excIn = '0;
   end

   // Pulse one request, then count cycles up to the vector jump
   task automatic send(input logic irq, input logic trap, input logic mem,
         input logic [11:0] code, input logic [7:0] imm, input logic [31:0] fa);
      eev_pkg::eev_exc_t req;
      req = {1'h1, irq, trap, mem, code, imm, fa};
      lastLat = 0;
      @(posedge clk);
      excIn <= req;
      @(posedge clk);
      // Payload not held: show a changed pattern, not the old one
      excIn <= {1'h0, ~req[$bits(req)-2:0]};
      do begin
         @(negedge clk);
         lastLat++;
      end while (excDone !== 1'h1 && lastLat < 12);
      timedOut = (excDone !== 1'h1);
   endtask
endmodule

// ---- tb/eev_top_bench.sv ----
`timescale 1ns/1ps
module eev_top_bench;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic manualResetReq = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [31:0] paddr = 32'h00000000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   eev_pkg::eev_exc_t excIn;
   logic excDone;
   logic irqOut;
   logic [31:0] rdv;
   int fails = 0;
   int cmpCount = 0;

   // =====================
   // Clock and instances
   always #50 clk = ~clk;

   eev_top i_dut (.clk(clk), .rst(rst), .manualResetReq(manualResetReq),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .excIn(excIn), .excDone(excDone), .irqOut(irqOut));

   eev_seq_model i_model (.clk(clk), .excIn(excIn), .excDone(excDone));

   // =====================
   // Shared tasks
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", cmpCount, fails);
      if (fails == 0 && cmpCount > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmpCount++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   // Request held until pready is seen high at an access edge
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      int n;
      @(posedge clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'h1 && n < 16);
      rdv = prdata;
      chk({31'h0, pslverr}, 32'h00000000);
      psel <= 1'h0;
      penable <= 1'h0;
      if (pready !== 1'h1) begin
         fails++;
         complete_run();
      end
   endtask

   task automatic rdChk(input logic [31:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h00000000);
      chk(rdv, exp);
   endtask

   task automatic exc(input logic irq, input logic trap, input logic mem,
         input logic [11:0] code, input logic [7:0] imm, input logic [31:0] fa);
      i_model.send(irq, trap, mem, code, imm, fa);
      if (i_model.timedOut) begin
         fails++;
         complete_run();
      end
      chk(32'(i_model.lastLat), 32'h00000003);
   endtask

   // Cause pin is held over the whole reset so the sync flops see it
   task automatic doReset(input logic manual);
      @(posedge clk);
      rst <= 1'h1;
      manualResetReq <= manual;
      repeat (20) @(posedge clk);
      rst <= 1'h0;
      manualResetReq <= 1'h0;
   endtask

   // =====================
   // Scenarios
   task automatic t_por();
      rdChk(eev_pkg::ADDR_GEN_EVENT, 32'h00000000);
      rdChk(eev_pkg::ADDR_IRQ_MIRROR, 32'h00000000);
      rdChk(32'h0FFFFFF0, 32'h00000000);
   endtask

   // Reserved bits written as zero, as software must; the mirror write must not land
   task automatic t_sw();
      logic [31:0] a [5];
      logic [31:0] w [5];
      logic [31:0] e [5];
      a = '{eev_pkg::ADDR_TRAP_IMM, eev_pkg::ADDR_GEN_EVENT, eev_pkg::ADDR_IRQ_EVENT,
         eev_pkg::ADDR_IRQ_MIRROR, eev_pkg::ADDR_FAULT_ADDR};
      w = '{32'h000003FC, 32'h00000FFF, 32'h00000FFF, 32'h00000FFF, 32'hA55A3CC3};
      e = '{32'h000003FC, 32'h00000FFF, 32'h00000FFF, 32'h00000000, 32'hA55A3CC3};
      for (int i = 0; i < 5; i++) begin
         apb(1'h1, a[i], w[i]);
         rdChk(a[i], e[i]);
      end
   endtask

   task automatic t_exc();
      apb(1'h1, eev_pkg::ADDR_IRQ_MASK, 32'h00000000);
      exc(1'h0, 1'h0, 1'h0, 12'h1E0, 8'h00, 32'h00000000);
      chk({31'h0, irqOut}, 32'h00000000);
      rdChk(eev_pkg::ADDR_GEN_EVENT, 32'h000001E0);
      rdChk(eev_pkg::ADDR_IRQ_EVENT, 32'h00000FFF);
      rdChk(eev_pkg::ADDR_FAULT_ADDR, 32'hA55A3CC3);
      rdChk(eev_pkg::ADDR_IRQ_STATUS, 32'h00000002);
      rdChk(eev_pkg::ADDR_IRQ_STATUS, 32'h00000000);
      apb(1'h1, eev_pkg::ADDR_IRQ_MASK, 32'h00000004);
      exc(1'h1, 1'h0, 1'h0, 12'h5A0, 8'h00, 32'h00000000);
      chk({31'h0, irqOut}, 32'h00000001);
      rdChk(eev_pkg::ADDR_IRQ_EVENT, 32'h000005A0);
      rdChk(eev_pkg::ADDR_IRQ_MIRROR, 32'h000005A0);
      rdChk(eev_pkg::ADDR_GEN_EVENT, 32'h000001E0);
      rdChk(eev_pkg::ADDR_IRQ_STATUS, 32'h00000004);
      @(negedge clk);
      chk({31'h0, irqOut}, 32'h00000000);
   endtask

   // Back-to-back: trap, then a memory fault
   task automatic t_trap();
      exc(1'h0, 1'h1, 1'h0, 12'h160, 8'hC3, 32'h00000000);
      exc(1'h0, 1'h0, 1'h1, 12'h0E0, 8'h00, 32'hDEADBEEF);
      rdChk(eev_pkg::ADDR_TRAP_IMM, 32'h0000030C);
      rdChk(eev_pkg::ADDR_FAULT_ADDR, 32'hDEADBEEF);
      rdChk(eev_pkg::ADDR_GEN_EVENT, 32'h000000E0);
   endtask

   // Software write lands on the same edge as the address capture
   task automatic t_conflict();
      fork
         exc(1'h0, 1'h0, 1'h1, 12'h100, 8'h00, 32'h13579BDF);
         begin
            @(posedge clk);
            apb(1'h1, eev_pkg::ADDR_FAULT_ADDR, 32'h2468ACE0);
         end
      join
      rdChk(eev_pkg::ADDR_FAULT_ADDR, 32'h13579BDF);
   endtask

   task automatic t_manual();
      doReset(1'h1);
      rdChk(eev_pkg::ADDR_GEN_EVENT, 32'h00000020);
   endtask

   // =====================
   // Main sequence
   initial begin
      doReset(1'h0);
      t_por();
      t_sw();
      t_exc();
      t_trap();
      t_conflict();
      t_manual();
      complete_run();
   end
endmodule
